// File: src/serial_link_param_regs.sv
// transmit link parameter registers with ahb-lite slave port
// assumes link fields outside this bank come from same-clock logic
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module serial_link_param_regs
#(
    parameter int ADDR_W = 32
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // link fields owned elsewhere, same clock
    input wire logic [7:0] i_dev_id,
    input wire logic [3:0] i_bank_id,
    input wire logic [4:0] i_lane0_id,
    input wire logic i_scramble,
    input wire logic [4:0] i_lanes_m1,
    input wire logic [7:0] i_octets_m1,
    input wire logic [4:0] i_frames_m1,
    input wire logic [7:0] i_conv_m1,
    input wire logic [4:0] i_samples_m1,
    input wire logic i_high_density,
    input wire logic [4:0] i_ctrl_words,
    // configuration towards the link layer
    output logic [1:0] o_ctrl_bits,
    output logic [4:0] o_resolution_m1,
    output logic [2:0] o_subclass,
    output logic [4:0] o_sample_bits_m1,
    output logic [7:0] o_lane0_checksum
);
    import link_param_pkg::*;
    // ========================================================
    // elaboration checks
    if (ADDR_W < 13)
    begin : g_addr_check
        $error("address too narrow for the register indices");
    end

    // ========================================================
    // state
    bus_state_t state; // bus phase tracker
    logic [10:0] cur_idx; // index latched in address phase
    logic cur_hit; // latched address is inside the decoded window and the access is word-sized
    logic accept; // address phase taken this edge
    logic hit; // address phase targets the decoded window
    logic [1:0] cs; // control bits per sample
    logic [4:0] res_m1; // converter resolution minus one
    logic [2:0] subclass; // subclass selection
    logic [4:0] np_m1; // bits per sample minus one
    logic [4:0] samples_m1; // read-only sample count copy
    logic hd; // read-only high density copy
    logic [4:0] cf; // read-only control word copy
    logic [7:0] chk0; // lane 0 checksum copy
    logic [31:0] next_rdata; // read mux result
    logic wr_cs_n; // write commit to the cs/n register
    logic wr_sc_np; // write commit to the subclass/n' register
    link_fields_if fields ();

    // ========================================================
    // address decode
    // upper address bits must be zero so aliases never hit
    assign hit = (i_haddr[ADDR_W-1:13] == '0);
    assign accept = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
    assign wr_cs_n = (state == BUS_WRITE) && cur_hit
        && (cur_idx == IDX_CS_N);
    assign wr_sc_np = (state == BUS_WRITE) && cur_hit
        && (cur_idx == IDX_SUBCLASS_NP);

    // ========================================================
    // bus phase tracker
    // reads take one wait state so a write just before is seen
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state <= BUS_IDLE;
            cur_idx <= 11'h000;
            cur_hit <= 1'b0;
        end
        else
        begin
            unique case (state)
                BUS_READ: state <= BUS_RDATA; // data loads now
                BUS_IDLE, BUS_WRITE, BUS_RDATA:
                begin
                    if (accept)
                    begin
                        state <= i_hwrite ? BUS_WRITE : BUS_READ;
                        cur_idx <= i_haddr[12:2];
                        cur_hit <= hit && (i_hsize == HSIZE_WORD);
                    end
                    else
                    begin
                        state <= BUS_IDLE;
                    end
                end
            endcase
        end
    end

    // ========================================================
    // ready and response
    // response is always okay; unmapped reads give zero
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            o_hresp <= 1'b0;
            if (state != BUS_READ && accept && !i_hwrite)
            begin
                o_hreadyout <= 1'b0; // one wait state on reads
            end
            else
            begin
                o_hreadyout <= 1'b1;
            end
        end
    end

    // ========================================================
    // read mux
    // reserved bits are constants, so writes cannot touch them
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (cur_hit)
        begin
            unique case (cur_idx)
                IDX_CS_N:
                begin
                    next_rdata[CS_LSB +: 2] = cs; // (R1) (R2)
                    next_rdata[RSVD_CS_BIT] = 1'b0; // (R11)
                    next_rdata[4:0] = res_m1; // (R3)
                end
                IDX_SUBCLASS_NP:
                begin
                    next_rdata[SUBCLASS_LSB +: 3] = subclass; // (R10)
                    next_rdata[4:0] = np_m1; // (R4)
                end
                IDX_SAMPLES:
                begin
                    next_rdata[VER_LSB +: 3] = RST_VER; // (R11)
                    next_rdata[4:0] = samples_m1; // (R5)
                end
                IDX_HD_CF:
                begin
                    next_rdata[HD_BIT] = hd; // (R6)
                    next_rdata[4:0] = cf; // (R7)
                end
                IDX_CHK0:
                begin
                    next_rdata[7:0] = chk0; // (R9)
                end
                default: next_rdata = 32'h0000_0000; // unmapped
            endcase
        end
    end

    // ========================================================
    // read data register
    // held until the next read so the master may sample late
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_hrdata <= 32'h0000_0000;
        end
        else if (state == BUS_READ)
        begin
            o_hrdata <= next_rdata;
        end
    end

    // ========================================================
    // cs and resolution register
    // out-of-range resolution codes are dropped, old value kept
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cs <= RST_CS; // (R2)
            res_m1 <= RST_RES; // (R3)
        end
        else if (wr_cs_n)
        begin
            cs <= i_hwdata[CS_LSB +: 2]; // (R1) (R2)
            if (i_hwdata[4:0] >= RES_MIN && i_hwdata[4:0] <= RES_MAX)
            begin
                res_m1 <= i_hwdata[4:0]; // (R3)
            end
        end
    end

    // ========================================================
    // subclass and bits-per-sample register
    // unlisted codes are dropped to keep the link consistent
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            subclass <= RST_SUBCLASS; // (R10)
            np_m1 <= RST_NP; // (R4)
        end
        else if (wr_sc_np)
        begin
            if (i_hwdata[SUBCLASS_LSB +: 3] == SUBCLASS_0
                || i_hwdata[SUBCLASS_LSB +: 3] == SUBCLASS_1)
            begin
                subclass <= i_hwdata[SUBCLASS_LSB +: 3]; // (R10)
            end
            if (i_hwdata[4:0] == NP_8 || i_hwdata[4:0] == NP_12
                || i_hwdata[4:0] == NP_16)
            begin
                np_m1 <= i_hwdata[4:0]; // (R4)
            end
        end
    end

    // ========================================================
    // read-only status copies
    // writes to these indices fall through without effect
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            samples_m1 <= 5'h00; // (R5)
            hd <= 1'b0; // (R6)
            cf <= 5'h00; // (R7)
        end
        else
        begin
            samples_m1 <= i_samples_m1; // (R5)
            hd <= i_high_density; // (R6)
            cf <= i_ctrl_words; // (R7)
        end
    end

    // ========================================================
    // checksum terms, one octet per lane 0 field
    assign fields.terms[0] = i_dev_id;
    assign fields.terms[1] = {4'h0, i_bank_id};
    assign fields.terms[2] = {3'h0, i_lane0_id};
    assign fields.terms[3] = {7'h00, i_scramble};
    assign fields.terms[4] = {3'h0, i_lanes_m1};
    assign fields.terms[5] = i_octets_m1;
    assign fields.terms[6] = {3'h0, i_frames_m1};
    assign fields.terms[7] = i_conv_m1;
    assign fields.terms[8] = {3'h0, res_m1};
    assign fields.terms[9] = {6'h00, cs};
    assign fields.terms[10] = {3'h0, np_m1};
    assign fields.terms[11] = {5'h00, subclass};
    assign fields.terms[12] = {3'h0, samples_m1};
    assign fields.terms[13] = {5'h00, RST_VER};
    assign fields.terms[14] = {7'h00, hd};
    assign fields.terms[15] = {3'h0, cf};

    link_checksum u_checksum
    (
        .fields(fields)
    );

    // ========================================================
    // checksum register, recomputed every cycle after reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            chk0 <= RST_CHK0; // (R9)
        end
        else
        begin
            chk0 <= fields.sum; // (R8)
        end
    end

    // ========================================================
    // configuration outputs, registered copies one cycle behind the registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_ctrl_bits <= RST_CS;
            o_resolution_m1 <= RST_RES;
            o_subclass <= RST_SUBCLASS;
            o_sample_bits_m1 <= RST_NP;
            o_lane0_checksum <= RST_CHK0;
        end
        else
        begin
            o_ctrl_bits <= cs;
            o_resolution_m1 <= res_m1;
            o_subclass <= subclass;
            o_sample_bits_m1 <= np_m1;
            o_lane0_checksum <= chk0;
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_read_req(logic [10:0] idx);
        accept && !i_hwrite && hit && i_hsize == HSIZE_WORD
            && i_haddr[12:2] == idx;
    endsequence
    sequence s_read_done;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    AST_CS_WRITE: assert property ( // (R1)
        wr_cs_n |=> cs == $past(i_hwdata[CS_LSB +: 2]))
        else $error("cs field did not take written code");
    AST_CS_RESET: assert property ( // (R2)
        $past(i_rst) |-> cs == CS_NONE && o_ctrl_bits == CS_NONE)
        else $error("cs field not zero after reset");
    AST_RES_RANGE: assert property ( // (R3)
        res_m1 >= RES_MIN && res_m1 <= RES_MAX)
        else $error("resolution left the 7 to 16 bit range");
    AST_NP_CODE: assert property ( // (R4)
        np_m1 == NP_8 || np_m1 == NP_12 || np_m1 == NP_16)
        else $error("bits per sample holds an unlisted code");
    AST_S_READ: assert property ( // (R5)
        s_read_req(IDX_SAMPLES) ##1 s_read_done
            |-> o_hrdata == {24'h0, RST_VER, $past(samples_m1)})
        else $error("samples register read back wrong");
    AST_HD_READ: assert property ( // (R6)
        s_read_req(IDX_HD_CF) ##1 s_read_done
            |-> o_hrdata[HD_BIT] == $past(hd)
            && o_hrdata[6:5] == 2'b00)
        else $error("high density bit read back wrong");
    AST_CF_READ: assert property ( // (R7)
        s_read_req(IDX_HD_CF) ##1 s_read_done
            |-> o_hrdata[4:0] == $past(cf))
        else $error("control word count read back wrong");
    AST_CHK_TRACK: assert property ( // (R8)
        !$past(i_rst) |-> o_lane0_checksum == $past(chk0)
            && chk0 == $past(fields.sum))
        else $error("checksum does not follow the fields");
    AST_CHK_RESET: assert property ( // (R9)
        $past(i_rst) |-> chk0 == RST_CHK0)
        else $error("checksum reset reading is not c3");
    AST_SUBCLASS: assert property ( // (R10)
        subclass == SUBCLASS_0 || subclass == SUBCLASS_1)
        else $error("subclass holds an unlisted code");
    AST_RSVD_CS: assert property ( // (R11)
        s_read_req(IDX_CS_N) ##1 s_read_done
            |-> o_hrdata[RSVD_CS_BIT] == 1'b0
            && o_hrdata[31:8] == 24'h0)
        else $error("reserved bit of cs register not zero");
endmodule

// File: src/link_param_pkg.sv
// Function
// (R1) CS code 2 upper two, 3 all
// (R2) CS code 0 none, 1 uppermost only
// (R3) N holds resolution-1, 7..16, resets 16
// (R4) N' codes 8/12/16 bits, resets 16
// (R5) S read-only [4:0], minus one, reset 0
// (R6) HD read-only bit 7, reset 0
// (R7) CF read-only [4:0], direct, reset 0
// (R8) lane checksum is parameter sum mod 256
// (R9) lane 0 checksum read-only, reads c3 at reset
// (R10) subclass [7:5]: 000 sc0, 001 sc1, reset 1
// (R11) reserved bits read-only, read reset value
//
// constants of the transmit link parameter register bank
// assumes word-indexed registers behind an ahb-lite slave
package link_param_pkg;
    // ========================================================
    // register indices (byte address is four times the index)
    localparam logic [10:0] IDX_CS_N = 11'h58f;
    localparam logic [10:0] IDX_SUBCLASS_NP = 11'h590;
    localparam logic [10:0] IDX_SAMPLES = 11'h591;
    localparam logic [10:0] IDX_HD_CF = 11'h592;
    localparam logic [10:0] IDX_CHK0 = 11'h5a0;
    // ========================================================
    // field positions
    localparam int CS_LSB = 6;
    localparam int RSVD_CS_BIT = 5;
    localparam int SUBCLASS_LSB = 5;
    localparam int HD_BIT = 7;
    localparam int VER_LSB = 5;
    // ========================================================
    // reset values
    localparam logic [1:0] RST_CS = 2'h0;
    localparam logic [4:0] RST_RES = 5'h0f;
    localparam logic [2:0] RST_SUBCLASS = 3'h1;
    localparam logic [4:0] RST_NP = 5'h0f;
    localparam logic [7:0] RST_CHK0 = 8'hc3;
    localparam logic [2:0] RST_VER = 3'h1;
    // ========================================================
    // field encodings
    localparam logic [1:0] CS_NONE = 2'h0;
    localparam logic [1:0] CS_TOP = 2'h1;
    localparam logic [1:0] CS_TOP_TWO = 2'h2;
    localparam logic [1:0] CS_ALL = 2'h3;
    localparam logic [4:0] RES_MIN = 5'h06;
    localparam logic [4:0] RES_MAX = 5'h0f;
    localparam logic [4:0] NP_8 = 5'h07;
    localparam logic [4:0] NP_12 = 5'h0b;
    localparam logic [4:0] NP_16 = 5'h0f;
    localparam logic [2:0] SUBCLASS_0 = 3'h0;
    localparam logic [2:0] SUBCLASS_1 = 3'h1;
    // ========================================================
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int NUM_TERMS = 16;
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10,
        BUS_RDATA = 2'b11
    } bus_state_t;
endpackage

// File: src/link_fields_if.sv
// link configuration fields carried from register bank to checksum
// assumes one clock domain; plain wires, no protocol
`timescale 1ns/10ps
interface link_fields_if;
    logic [7:0] terms [link_param_pkg::NUM_TERMS]; // one octet per field
    logic [7:0] sum; // sum modulo 256
    modport src
    (
        output terms,
        input sum
    );
    modport sink
    (
        input terms,
        output sum
    );
endinterface

// File: src/link_checksum.sv
// modulo-256 sum of the lane configuration fields
// assumes fields arrive already aligned to the low bits
`timescale 1ns/10ps
module link_checksum
(
    link_fields_if.sink fields
);
    import link_param_pkg::*;
    // ========================================================
    // sum of all fields, the carry out of bit 7 is dropped
    always_comb
    begin
        logic [7:0] acc;
        acc = 8'h00;
        for (int t = 0; t < NUM_TERMS; t++)
        begin
            acc = acc + fields.terms[t]; // wraps modulo 256
        end
        fields.sum = acc; // (R8)
    end
endmodule

// File: verif/serial_link_param_regs_tb_top.sv
// self-checking bench for the link parameter register bank
// assumes the bank is the only slave of one ahb-lite master
`timescale 1ns/10ps
module serial_link_param_regs_tb_top;
    import link_param_pkg::*;
    // ========================================================
    // clock, reset and bus master signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    // link fields fed from outside the bank, all randomised
    logic [7:0] dev_id = 8'h0, octets = 8'h0, conv = 8'h0;
    logic [4:0] lane0_id = 5'h0, lanes = 5'h0, frames = 5'h0;
    logic [4:0] samples = 5'h0, cw = 5'h0;
    logic [3:0] bank_id = 4'h0;
    logic scramble = 1'b0, hd = 1'b0;
    // configuration outputs
    logic [1:0] o_cs;
    logic [4:0] o_res, o_np;
    logic [2:0] o_sc;
    logic [7:0] o_chk;
    // bench model of the writable fields
    logic [1:0] m_cs = RST_CS;
    logic [4:0] m_res = RST_RES, m_np = RST_NP;
    logic [2:0] m_sc = RST_SUBCLASS;
    logic [15:0] lfsr;
    int fails = 0;
    int n_compared = 0;

    always #5 clk = ~clk; // 100 mhz

    serial_link_param_regs serial_link_param_regs_i
    (
        .i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .i_dev_id(dev_id),
        .i_bank_id(bank_id), .i_lane0_id(lane0_id),
        .i_scramble(scramble), .i_lanes_m1(lanes),
        .i_octets_m1(octets), .i_frames_m1(frames), .i_conv_m1(conv),
        .i_samples_m1(samples), .i_high_density(hd),
        .i_ctrl_words(cw), .o_ctrl_bits(o_cs), .o_resolution_m1(o_res),
        .o_subclass(o_sc), .o_sample_bits_m1(o_np),
        .o_lane0_checksum(o_chk)
    );

    // ========================================================
    // helpers
    // lfsr draw; fixed start keeps runs repeatable
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // byte address of a word-indexed register
    function automatic logic [31:0] ad(input logic [10:0] idx);
        return {19'h0, idx, 2'b00};
    endfunction

    // expected lane 0 sum, all terms zero-extended, wraps at 256
    function automatic logic [7:0] exp_chk();
        logic [7:0] s;
        s = dev_id + bank_id + lane0_id + scramble + lanes + octets;
        s = s + frames + conv + m_res + m_cs + m_np + m_sc;
        return s + samples + RST_VER + hd + cw;
    endfunction

    // new random link fields, driven just after an edge
    task automatic new_fields();
        logic [15:0] a, b, c;
        a = rnd();
        b = rnd();
        c = rnd();
        dev_id <= a[7:0];
        bank_id <= a[11:8];
        scramble <= a[12];
        hd <= a[13];
        octets <= b[7:0];
        conv <= b[15:8];
        lane0_id <= c[4:0];
        lanes <= c[9:5];
        frames <= c[14:10];
        samples <= a[4:0] ^ b[12:8];
        cw <= c[15:11] ^ a[4:0];
    endtask

    // one ahb-lite single transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] wd, input logic [2:0] sz,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= sz;
        @(posedge clk);
        // no wait count assumed; a slave that never answers is
        // caught by the watchdog
        while (hreadyout !== 1'b1)
        begin
            @(posedge clk);
        end
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = hrdata;
    endtask

    task automatic wr(input logic [10:0] idx, input logic [7:0] d);
        logic [31:0] x;
        xfer(1'b1, ad(idx), {24'h0, d}, HSIZE_WORD, x);
    endtask

    // compare of a port or a computed value
    task automatic cmp(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // compare of a register read; the response must stay okay
    task automatic cmp_read(input logic [31:0] a, input logic [7:0] exp,
        input string what);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0, HSIZE_WORD, d);
        cmp(what, {24'h0, exp}, d);
        cmp("response", 32'h0, {31'h0, hresp});
    endtask

    // port copies against the model
    task automatic cmp_ports();
        cmp("ctrl_bits port", m_cs, o_cs);
        cmp("resolution port", m_res, o_res);
        cmp("subclass port", m_sc, o_sc);
        cmp("sample bits port", m_np, o_np);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ========================================================
    // tests
    initial
    begin
        static logic [4:0] res_tab [5] = '{5'h05, 5'h10, 5'h06, 5'h1f, 5'h0f};
        static logic [4:0] np_tab [5] = '{NP_8, 5'h03, NP_12, 5'h1f, NP_16};
        static logic [2:0] sc_tab [5] = '{SUBCLASS_0, 3'h2, SUBCLASS_1, 3'h7,
            SUBCLASS_0};
        logic [4:0] r5;
        logic [31:0] d;
        lfsr = 16'h0004;
        // fields change just after an edge, reset spans 8 edges
        @(posedge clk);
        new_fields();
        repeat (7) @(posedge clk);
        // reset values while reset is still held
        cmp("checksum port", RST_CHK0, o_chk);
        cmp_ports();
        rst <= 1'b0;
        @(posedge clk);
        cmp_read(ad(IDX_CS_N), {RST_CS, 1'b0, RST_RES}, "ctrl_res");
        cmp_read(ad(IDX_SUBCLASS_NP), 8'h2f, "subclass_np");
        $display("test reset done");
        // every control bit code, reserved bit written as one
        for (int cs = 0; cs < 4; cs++)
        begin
            r5 = RES_MIN + 5'(rnd() % 10);
            wr(IDX_CS_N, {2'(cs), 1'b1, r5});
            m_cs = 2'(cs);
            m_res = r5;
            cmp_read(ad(IDX_CS_N), {m_cs, 1'b0, m_res}, "cs_n");
            cmp_ports();
        end
        $display("test control bits done");
        // legal and illegal codes; illegal ones leave the field alone
        for (int i = 0; i < 5; i++)
        begin
            wr(IDX_CS_N, {2'(i), 1'b0, res_tab[i]});
            m_cs = 2'(i);
            if (res_tab[i] >= RES_MIN && res_tab[i] <= RES_MAX)
                m_res = res_tab[i];
            wr(IDX_SUBCLASS_NP, {sc_tab[i], np_tab[i]});
            if (sc_tab[i] <= SUBCLASS_1)
                m_sc = sc_tab[i];
            if (np_tab[i] inside {NP_8, NP_12, NP_16})
                m_np = np_tab[i];
            cmp_read(ad(IDX_CS_N), {m_cs, 1'b0, m_res}, "ctrl_res");
            cmp_read(ad(IDX_SUBCLASS_NP), {m_sc, m_np}, "sc_np");
            cmp_ports();
        end
        $display("test codes done");
        // read-only registers ignore writes and track their sources
        for (int i = 0; i < 8; i++)
        begin
            new_fields();
            wr(IDX_SAMPLES, 8'hff);
            wr(IDX_HD_CF, 8'hff);
            wr(IDX_CHK0, 8'h00);
            cmp_read(ad(IDX_SAMPLES), {RST_VER, samples}, "samples");
            cmp_read(ad(IDX_HD_CF), {hd, 2'b00, cw}, "hd_cf");
            cmp("checksum port", exp_chk(), o_chk);
            cmp_read(ad(IDX_CHK0), exp_chk(), "checksum");
        end
        $display("test read-only done");
        // unmapped places read zero and a byte-sized write is refused
        cmp_read(ad(11'h593), 8'h00, "unmapped");
        cmp_read(ad(IDX_CS_N) | 32'h2000, 8'h00, "high address");
        xfer(1'b1, ad(IDX_CS_N), 32'h0, 3'h0, d);
        cmp_read(ad(IDX_CS_N), {m_cs, 1'b0, m_res}, "byte write");
        $display("test refusals done");
        wrap_up();
    end

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule
